/* File: common/bpsp_pkg.sv */
// Constants and types for the buck sequencing and protection block
`default_nettype none

package bpsp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_KHZ = 20000;
    localparam int unsigned CLK_NS = 50;
    localparam int unsigned OSC_KHZ = 750;
    localparam int unsigned OSC_DIV = CLK_KHZ / OSC_KHZ;
    localparam int OSC_W = 5;
    localparam int unsigned SYNC_MIN_KHZ = 500;
    localparam int unsigned SYNC_MISS_EDGES = 4;
    localparam int unsigned SYNC_MISS_CYC = SYNC_MISS_EDGES * (CLK_KHZ / SYNC_MIN_KHZ);
    localparam int MISS_W = 8;
    localparam int unsigned DEAD_NS = 100;
    localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEAD_W = 2;
    localparam int unsigned RST_HOLD_MS = 25;
    localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
    localparam int RST_CNT_W = 20;

    ////////////////////////////////////////////////////////////////////////
    // Sequencing and fault counts
    localparam logic [12:0] SS_CYCLES = 13'h1000;
    localparam logic [3:0] OC_TRIP = 4'hf;
    localparam logic [4:0] RESTART_TICKS = 5'h10;
    localparam logic [5:0] OV_TRIP = 6'h20;

    ////////////////////////////////////////////////////////////////////////
    // Pin input vector positions
    localparam int PIN_EN = 0;
    localparam int PIN_LOCK = 1;
    localparam int PIN_HI = 2;
    localparam int PIN_LO = 3;
    localparam int PIN_SYNC = 4;
    localparam int PIN_ILIM = 5;
    localparam int PIN_OC = 6;
    localparam int PIN_OV = 7;
    localparam int PIN_WIN = 8;
    localparam int PIN_BOR = 9;
    localparam int PIN_N = 10;

    typedef enum logic [1:0] {
        LVL_LOW = 2'h0,
        LVL_MID = 2'h1,
        LVL_UPPER = 2'h2
    } bpsp_level_e;

    // Gray along off, high, dead, low
    typedef enum logic [1:0] {
        PH_OFF = 2'h0,
        PH_HIGH = 2'h1,
        PH_DEAD = 2'h3,
        PH_LOW = 2'h2
    } bpsp_phase_e;

endpackage : bpsp_pkg

`default_nettype wire

/* File: common/bpsp_clk_if.sv */
// Switching clock selection signals between core and clock selector
`timescale 1ns/1ns
`default_nettype none

interface bpsp_clk_if;
    logic run;
    logic sync_edge;
    logic tick;
    logic sync_mode;
    modport core (output run, output sync_edge, input tick, input sync_mode);
    modport clk_sel (input run, input sync_edge, output tick, output sync_mode);
endinterface : bpsp_clk_if

`default_nettype wire

/* File: design/bpsp_clk_sel.sv */
// Internal oscillator divider and external sync selection
`timescale 1ns/1ns
`default_nettype none

module bpsp_clk_sel
    import bpsp_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    bpsp_clk_if.clk_sel cs
);

    logic [OSC_W-1:0] osc_q, osc_d;
    logic [MISS_W-1:0] miss_q, miss_d;
    logic mode_q, mode_d;
    logic tick_q, tick_d;

    always_comb begin
        osc_d = osc_q;
        miss_d = miss_q;
        mode_d = mode_q;
        tick_d = 1'b0;
        if (!cs.run) begin
            // Oscillator stopped in shutdown
            osc_d = '0;
            miss_d = '0;
            mode_d = 1'b0;
        end else if (cs.sync_edge) begin
            osc_d = '0;
            miss_d = '0;
            mode_d = 1'b1;
            tick_d = 1'b1;
        end else if (mode_q) begin
            if (miss_q == MISS_W'(SYNC_MISS_CYC - 1)) begin
                // Fall back with an immediate tick so no cycle is lost
                mode_d = 1'b0;
                miss_d = '0;
                osc_d = '0;
                tick_d = 1'b1;
            end else begin
                miss_d = miss_q + 8'h01;
            end
        end else if (osc_q == OSC_W'(OSC_DIV - 1)) begin
            osc_d = '0;
            tick_d = 1'b1;
        end else begin
            osc_d = osc_q + 5'h01;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osc_q <= '0;
            miss_q <= '0;
            mode_q <= 1'b0;
            tick_q <= 1'b0;
        end else begin
            osc_q <= osc_d;
            miss_q <= miss_d;
            mode_q <= mode_d;
            tick_q <= tick_d;
        end
    end

    assign cs.tick = tick_q;
    assign cs.sync_mode = mode_q;

    ////////////////////////////////////////////////////////////////////////
    chk_internal_tick:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (cs.run && !mode_q && !cs.sync_edge && osc_q == OSC_W'(OSC_DIV - 1)) |=> tick_q && !mode_q)
        else $error("internal oscillator tick missing");
    chk_sync_lock:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (cs.run && cs.sync_edge) |=> tick_q && mode_q ##1 !tick_q)
        else $error("sync edge did not start a cycle");
    chk_sync_fallback:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (cs.run && mode_q && !cs.sync_edge && miss_q == MISS_W'(SYNC_MISS_CYC - 1)) |=> !mode_q && tick_q)
        else $error("no fallback after missing sync edges");
    chk_stop_osc:
    assert property (@(posedge clk_in) disable iff (!rst_n_in)
        !cs.run |=> !tick_q && !mode_q)
        else $error("oscillator running in shutdown");

endmodule : bpsp_clk_sel

`default_nettype wire

/* File: design/bpsp_top.sv */
// Buck regulator sequencing, switch timing and protection core
`timescale 1ns/1ns
`default_nettype none

module bpsp_top
    import bpsp_pkg::*;
#(
    parameter int unsigned RST_HOLD_CYCLES = RST_HOLD_CYC
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic enable_in,
    input wire logic supply_lockout_in,
    input wire logic output_level_select_hi_in,
    input wire logic output_level_select_lo_in,
    input wire logic sync_in,
    input wire logic current_limit_in,
    input wire logic overcurrent_in,
    input wire logic overvoltage_in,
    input wire logic output_feedback_ok_in,
    input wire logic supply_below_reset_in,
    output logic [1:0] output_setting_out,
    output logic high_side_on_out,
    output logic low_side_on_out,
    output logic [11:0] soft_start_ramp_out,
    output logic reference_direct_out,
    output logic converter_active_out,
    output logic sync_locked_out,
    output logic regulation_ok_out,
    output logic regulation_ok_pin_out,
    output logic regulation_ok_oe_n_out,
    output logic supervisor_reset_n_out
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    bpsp_clk_if cs ();

    logic [PIN_N-1:0] pins;
    logic [PIN_N-1:0] s1_q, s2_q, s3_q;
    logic [PIN_N-1:0] filt_q, filt_d;
    logic sync_edge_q, sync_edge_d;
    bpsp_level_e lvl_q, lvl_d;
    bpsp_phase_e phase_q, phase_d;
    logic [DEAD_W-1:0] dead_q, dead_d;
    logic [12:0] ss_cnt_q, ss_cnt_d;
    logic [3:0] oc_cnt_q, oc_cnt_d;
    logic [5:0] ov_cnt_q, ov_cnt_d;
    logic restart_q, restart_d;
    logic [4:0] rwait_q, rwait_d;
    logic hs_q, hs_d, ls_q, ls_d;
    logic [11:0] ramp_q, ramp_d;
    logic ref_q, ref_d;
    logic reg_ok_q, reg_ok_d;
    logic [RST_CNT_W-1:0] rcnt_q, rcnt_d;
    logic rstn_q, rstn_d;
    logic run, cnt_en, tick, oc_trip, ov_trip, sw_ok;

    assign pins = {supply_below_reset_in, output_feedback_ok_in, overvoltage_in, overcurrent_in,
                   current_limit_in, sync_in, output_level_select_lo_in, output_level_select_hi_in,
                   supply_lockout_in, enable_in};

    // Lockout stops the converter, the reset output does not
    assign run = filt_q[PIN_EN] & ~filt_q[PIN_LOCK];
    assign cnt_en = run & ~restart_q;
    assign tick = cs.tick;
    assign cs.run = run;
    assign cs.sync_edge = sync_edge_q;

    bpsp_clk_sel u_clk_sel (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .cs(cs)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        // A pin change counts once second and third stages agree
        filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
        sync_edge_d = filt_d[PIN_SYNC] & ~filt_q[PIN_SYNC];

        // Both levels at once is not a legal pin state; middle is safest
        case ({filt_q[PIN_HI], filt_q[PIN_LO]})
            2'b10: lvl_d = LVL_UPPER;
            2'b01: lvl_d = LVL_LOW;
            default: lvl_d = LVL_MID;
        endcase

        ss_cnt_d = ss_cnt_q;
        oc_cnt_d = oc_cnt_q;
        ov_cnt_d = ov_cnt_q;
        restart_d = restart_q;
        rwait_d = rwait_q;
        oc_trip = 1'b0;
        ov_trip = 1'b0;
        if (!run) begin
            ss_cnt_d = '0;
            oc_cnt_d = '0;
            ov_cnt_d = '0;
            restart_d = 1'b0;
            rwait_d = '0;
        end else if (tick) begin
            if (restart_q) begin
                if (rwait_q == RESTART_TICKS - 5'h01) begin
                    restart_d = 1'b0;
                    oc_cnt_d = '0;
                end
                rwait_d = rwait_q + 5'h01;
            end else begin
                if (filt_q[PIN_OC]) begin
                    if (oc_cnt_q != OC_TRIP) begin
                        oc_cnt_d = oc_cnt_q + 4'h1;
                    end
                end else if (oc_cnt_q != 4'h0) begin
                    oc_cnt_d = oc_cnt_q - 4'h1;
                end
                if (oc_cnt_d == OC_TRIP) begin
                    oc_trip = 1'b1;
                    restart_d = 1'b1;
                    rwait_d = '0;
                end
                ov_cnt_d = filt_q[PIN_OV] ? ov_cnt_q + 6'h01 : 6'h00;
                if (ov_cnt_d == OV_TRIP) begin
                    ov_trip = 1'b1;
                    ov_cnt_d = '0;
                end
                if (oc_trip || ov_trip) begin
                    ss_cnt_d = '0;
                end else if (ss_cnt_q != SS_CYCLES) begin
                    // Counts switching cycles, so time scales with frequency
                    ss_cnt_d = ss_cnt_q + 13'h0001;
                end
            end
        end

        sw_ok = cnt_en & ~oc_trip & ~ov_trip;
        phase_d = phase_q;
        dead_d = dead_q;
        if (!sw_ok) begin
            phase_d = PH_OFF;
        end else if (tick) begin
            phase_d = PH_HIGH;
        end else begin
            case (phase_q)
                PH_HIGH: begin
                    if (filt_q[PIN_ILIM]) begin
                        phase_d = PH_DEAD;
                        dead_d = DEAD_W'(DEAD_CYC - 1);
                    end
                end
                PH_DEAD: begin
                    // Both switches off to avoid shoot-through
                    if (dead_q == '0) begin
                        phase_d = PH_LOW;
                    end else begin
                        dead_d = dead_q - 2'h1;
                    end
                end
                default: begin
                    phase_d = phase_q;
                end
            endcase
        end
        hs_d = (phase_d == PH_HIGH);
        ls_d = (phase_d == PH_LOW);

        ramp_d = ss_cnt_d[12] ? 12'hfff : ss_cnt_d[11:0];
        ref_d = (ss_cnt_d == SS_CYCLES);
        reg_ok_d = run & filt_q[PIN_WIN];

        rcnt_d = rcnt_q;
        rstn_d = rstn_q;
        if (filt_q[PIN_BOR]) begin
            rcnt_d = '0;
            rstn_d = 1'b0;
        end else if (rcnt_q != RST_CNT_W'(RST_HOLD_CYCLES - 1)) begin
            rcnt_d = rcnt_q + 20'h00001;
            rstn_d = 1'b0;
        end else begin
            rstn_d = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
            sync_edge_q <= 1'b0;
            lvl_q <= LVL_MID;
            phase_q <= PH_OFF;
            dead_q <= '0;
            ss_cnt_q <= '0;
            oc_cnt_q <= '0;
            ov_cnt_q <= '0;
            restart_q <= 1'b0;
            rwait_q <= '0;
            hs_q <= 1'b0;
            ls_q <= 1'b0;
            ramp_q <= '0;
            ref_q <= 1'b0;
            reg_ok_q <= 1'b0;
            rcnt_q <= '0;
            rstn_q <= 1'b0;
        end else begin
            s1_q <= pins;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
            sync_edge_q <= sync_edge_d;
            lvl_q <= lvl_d;
            phase_q <= phase_d;
            dead_q <= dead_d;
            ss_cnt_q <= ss_cnt_d;
            oc_cnt_q <= oc_cnt_d;
            ov_cnt_q <= ov_cnt_d;
            restart_q <= restart_d;
            rwait_q <= rwait_d;
            hs_q <= hs_d;
            ls_q <= ls_d;
            ramp_q <= ramp_d;
            ref_q <= ref_d;
            reg_ok_q <= reg_ok_d;
            rcnt_q <= rcnt_d;
            rstn_q <= rstn_d;
        end
    end

    assign output_setting_out = lvl_q;
    assign high_side_on_out = hs_q;
    assign low_side_on_out = ls_q;
    assign soft_start_ramp_out = ramp_q;
    assign reference_direct_out = ref_q;
    assign converter_active_out = run;
    assign sync_locked_out = cs.sync_mode;
    assign regulation_ok_out = reg_ok_q;
    // Open drain: pulls low unless regulation is ok
    assign regulation_ok_pin_out = 1'b0;
    assign regulation_ok_oe_n_out = reg_ok_q;
    assign supervisor_reset_n_out = rstn_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    chk_level_upper:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        (filt_q[PIN_HI] && !filt_q[PIN_LO]) |=> lvl_q == LVL_UPPER)
        else $error("upper level not decoded");
    chk_dead_gap:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        $fell(hs_q) |-> !ls_q ##1 !ls_q)
        else $error("low side on without dead time");
    chk_ss_complete:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        $rose(ref_q) |-> ss_cnt_q == 13'h1000 && $past(ss_cnt_q) == 13'h0fff)
        else $error("reference switched before 4096 cycles");
    chk_off_when_stopped:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        !run |=> !hs_q && !ls_q && ss_cnt_q == 13'h0000)
        else $error("switching while disabled or locked out");
    chk_reg_ok_low:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        !run |=> !reg_ok_q && regulation_ok_oe_n_out == 1'b0)
        else $error("regulation ok high while disabled");
    chk_oc_increment:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        (run && tick && !restart_q && filt_q[PIN_OC] && oc_cnt_q < 4'he) |=> oc_cnt_q == $past(oc_cnt_q) + 4'h1)
        else $error("overcurrent count did not increment");
    chk_oc_floor:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        (run && tick && !restart_q && !filt_q[PIN_OC] && oc_cnt_q == 4'h0) |=> oc_cnt_q == 4'h0)
        else $error("overcurrent count wrapped below zero");
    chk_oc_shutdown:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        (run && tick && !restart_q && filt_q[PIN_OC] && oc_cnt_q == 4'he)
            |=> restart_q && !hs_q && ss_cnt_q == 13'h0)
        else $error("no shutdown at full overcurrent count");
    chk_oc_restart:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        (run && tick && restart_q && rwait_q == 5'h0f) |=> !restart_q && oc_cnt_q == 4'h0 && ss_cnt_q == 13'h0)
        else $error("restart not after 16 cycles");
    chk_ov_trip:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        (run && tick && !restart_q && filt_q[PIN_OV] && ov_cnt_q == 6'h1f)
            |=> !hs_q && ss_cnt_q == 13'h0 && ov_cnt_q == 6'h0)
        else $error("overvoltage did not stop switching");
    chk_reset_low:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        filt_q[PIN_BOR] |=> !rstn_q ##1 !rstn_q)
        else $error("reset output released too early");
    chk_fault_clear:
    assert property (@(posedge clk_in) disable iff (!rst_n)
        !run |=> oc_cnt_q == 4'h0 && ov_cnt_q == 6'h00 && !restart_q)
        else $error("fault counters not cleared when stopped");

endmodule : bpsp_top

`default_nettype wire

/* File: verif/bpsp_sync_src.sv */
// External synchronization clock source model
`timescale 1ns/1ns
`default_nettype none

module bpsp_sync_src (
    input wire logic clk_in,
    input wire logic run_in,
    input wire logic [7:0] half_in,
    output logic sync_out
);
    logic [7:0] cnt_q = 8'h00;
    logic lvl_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Stands low when stopped, so a halted source shows missing edges
    always @(posedge clk_in) begin
        if (!run_in) begin
            cnt_q <= 8'h00;
            lvl_q <= 1'b0;
        end else if (cnt_q == half_in - 8'h01) begin
            cnt_q <= 8'h00;
            lvl_q <= ~lvl_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
    assign sync_out = lvl_q;
endmodule : bpsp_sync_src

`default_nettype wire

/* File: verif/buck_pwm_sequencing_protection_test.sv */
// Self-checking bench for the buck sequencing and protection core
`timescale 1ns/1ns
`default_nettype none

module buck_pwm_sequencing_protection_test
    import bpsp_pkg::*;
;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic en = 1'b0, lock = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0, sync_run = 1'b0;
    logic ilim_en = 1'b0, oc = 1'b0, ov = 1'b0, fb_ok = 1'b0, below = 1'b0;
    logic current_limit_in = 1'b0;
    logic sync_in, high_side, low_side, ref_dir, active, locked, reg_ok, reg_pin, reg_oe_n, sup_n;
    logic [1:0] setting;
    logic [11:0] ramp;
    logic [1:0] sel_t [4] = '{2'b10, 2'b01, 2'b00, 2'b11};
    logic [1:0] lvl_t [4] = '{LVL_UPPER, LVL_LOW, LVL_MID, LVL_MID};
    logic hs_prev = 1'b0;
    int failures = 0, checks = 0, rises = 0, cyc = 0, last_rise = 0, period = 0;

    always #25 clk_in = ~clk_in;

    bpsp_top #(.RST_HOLD_CYCLES(20)) DUT (.clk_in(clk_in), .resetn_in(resetn_in), .enable_in(en),
        .supply_lockout_in(lock), .output_level_select_hi_in(sel_hi), .output_level_select_lo_in(sel_lo),
        .sync_in(sync_in), .current_limit_in(current_limit_in), .overcurrent_in(oc), .overvoltage_in(ov),
        .output_feedback_ok_in(fb_ok), .supply_below_reset_in(below), .output_setting_out(setting),
        .high_side_on_out(high_side), .low_side_on_out(low_side), .soft_start_ramp_out(ramp),
        .reference_direct_out(ref_dir), .converter_active_out(active), .sync_locked_out(locked),
        .regulation_ok_out(reg_ok), .regulation_ok_pin_out(reg_pin), .regulation_ok_oe_n_out(reg_oe_n),
        .supervisor_reset_n_out(sup_n));

    bpsp_sync_src partner (.clk_in(clk_in), .run_in(sync_run), .half_in(8'h0a), .sync_out(sync_in));

    ////////////////////////////////////////////////////////////////////////
    // Switch monitor; current sense trips one clock after the high side turns on
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        hs_prev <= high_side;
        current_limit_in <= ilim_en & high_side;
        if (high_side === 1'b1 && hs_prev === 1'b0) begin
            rises <= rises + 1;
            period <= cyc - last_rise;
            last_rise <= cyc;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick

    task automatic wait_rises(input int k);
        int t;
        int n;
        t = rises + k;
        n = 0;
        while (rises < t && n < 2000) begin
            tick(1);
            n++;
        end
    endtask : wait_rises

    task report_and_stop;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // Run span covers the full soft start at the fastest sync rate
    initial begin
        #(95000 * CLK_NS);
        failures++;
        report_and_stop();
    end

    initial begin
        int n, r0, c0, i;
        logic [11:0] a;
        tick(20);
        resetn_in <= 1'b1;
        tick(3);
        check(setting, LVL_MID);
        check({active, high_side, reg_ok}, 32'h0);
        for (i = 0; i < 4; i++) begin
            {sel_hi, sel_lo} <= sel_t[i];
            tick(8);
            check(setting, lvl_t[i]);
        end
        lock <= 1'b1;
        en <= 1'b1;
        fb_ok <= 1'b1;
        tick(100);
        check({active, 31'(rises)}, 32'h0);
        lock <= 1'b0;
        ilim_en <= 1'b1;
        sync_run <= 1'b1;
        wait_rises(3);
        check({active, reg_ok, reg_oe_n, reg_pin}, 32'he);
        check(locked, 1'b1);
        check(period, 20);
        a = ramp;
        wait_rises(1);
        check(ramp, a + 12'h001);
        n = 0;
        while (ref_dir !== 1'b1 && n < 90000) begin
            tick(1);
            n++;
        end
        check({31'h0, rises >= 4095 && rises <= 4098}, 32'h1);
        check({ref_dir, ramp}, 13'h1fff);
        wait_rises(1);
        n = 0;
        while (high_side !== 1'b0 && n < 2000) begin
            tick(1);
            n++;
        end
        n = 0;
        while (low_side !== 1'b1 && n < 20) begin
            check(high_side, 1'b0);
            tick(1);
            n++;
        end
        check(n, DEAD_CYC);
        sync_run <= 1'b0;
        n = 0;
        while (locked !== 1'b0 && n < 300) begin
            tick(1);
            n++;
        end
        wait_rises(2);
        check({locked, period[30:0]}, OSC_DIV);
        oc <= 1'b1;
        r0 = rises;
        n = 0;
        while (ref_dir !== 1'b0 && n < 1100) begin
            tick(1);
            n++;
        end
        // No wrap below zero after thousands of normal samples
        check(rises - r0, 14);
        check(ramp, 12'h000);
        oc <= 1'b0;
        c0 = cyc;
        wait_rises(1);
        check({31'h0, (cyc - c0) >= 15 * OSC_DIV && (cyc - c0) <= 18 * OSC_DIV}, 32'h1);
        wait_rises(3);
        ov <= 1'b1;
        r0 = rises;
        n = 0;
        while (ramp !== 12'h000 && n < 1100) begin
            tick(1);
            n++;
        end
        check(rises - r0, 31);
        ov <= 1'b0;
        below <= 1'b1;
        tick(8);
        check(sup_n, 1'b0);
        r0 = rises;
        tick(60);
        check({31'h0, rises > r0}, 32'h1);
        below <= 1'b0;
        tick(22);
        check(sup_n, 1'b0);
        tick(10);
        check(sup_n, 1'b1);
        fb_ok <= 1'b0;
        tick(8);
        check({reg_ok, reg_oe_n}, 2'h0);
        fb_ok <= 1'b1;
        en <= 1'b0;
        tick(8);
        check({active, high_side, low_side, reg_ok}, 4'h0);
        r0 = rises;
        tick(60);
        check(rises, r0);
        report_and_stop();
    end
endmodule : buck_pwm_sequencing_protection_test

`default_nettype wire
